// *** verilog/scs_clock_select.sv ***
// System clock source select with oscillator control registers
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"

module scs_clock_select (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// Special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output var  logic [7:0] sfr_rdata,
	// External clock pin
	input  wire logic       external_clock_pin,
	// Clock and oscillator controls
	output var  logic       core_clock,
	output var  logic       core_clock_is_ext,
	output var  logic       hf_osc_on,
	output var  logic       hf_osc_freq_ready,
	output var  logic [2:0] ext_osc_mode_sel,
	output var  logic [2:0] ext_osc_range_ctrl,
	output var  logic       ext_pin_claim
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	scs_pkg::scs_state_t state_reg;
	scs_pkg::scs_state_t state_next;

	logic       wr_int;
	logic       wr_ext;
	logic       int_tick;
	logic       ext_edge;
	logic       ext_tick;
	logic       ext_run;
	logic       ext_halved;
	logic [2:0] div_mask;

	function automatic logic [2:0] mask_of(input logic [1:0] div);
		case (div)
			2'h0:    mask_of = 3'h7;
			2'h1:    mask_of = 3'h3;
			2'h2:    mask_of = 3'h1;
			default: mask_of = 3'h0;
		endcase
	endfunction

	function automatic logic mode_runs(input scs_pkg::scs_ext_mode_t m);
		case (m)
			scs_pkg::SCS_EXT_CMOS,
			scs_pkg::SCS_EXT_CMOS_D2,
			scs_pkg::SCS_EXT_RC_D2,
			scs_pkg::SCS_EXT_CAP_D2: mode_runs = 1'b1;
			default:                 mode_runs = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Tick generation
	// ----------------------------------------
	always_comb begin
		wr_int     = sfr_wr && (sfr_addr == `SCS_INT_CTRL_ADDR);
		wr_ext     = sfr_wr && (sfr_addr == `SCS_EXT_CTRL_ADDR);
		div_mask   = mask_of(state_reg.act_div);
		// Internal oscillator modelled as one tick per mclk while on
		int_tick   = state_reg.hf_on &&
			((state_reg.div_cnt & div_mask) == div_mask);
		ext_run    = mode_runs(state_reg.ext_mode);
		ext_halved = ext_run &&
			(state_reg.ext_mode != scs_pkg::SCS_EXT_CMOS);
		ext_edge   = ext_run && external_clock_pin && !state_reg.pin_q;
		ext_tick   = ext_edge && (!ext_halved || state_reg.ext_half);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		if (wr_int) begin
			// Upper bits and ready flag are not stored
			state_next.clk_sel = sfr_wdata[`SCS_INT_SEL_BIT];
			state_next.hf_on   = sfr_wdata[`SCS_INT_ON_BIT];
			state_next.hf_div  =
				sfr_wdata[`SCS_INT_DIV_HI:`SCS_INT_DIV_LO];
		end
		if (wr_ext) begin
			state_next.ext_mode = scs_pkg::scs_ext_mode_t'(
				sfr_wdata[`SCS_EXT_MODE_HI:`SCS_EXT_MODE_LO]);
			state_next.ext_range =
				sfr_wdata[`SCS_EXT_RANGE_HI:`SCS_EXT_RANGE_LO];
		end
		// Restart settles only after the oscillator was switched off
		if (!state_reg.hf_on) begin
			state_next.start_cnt = 3'h0;
		end else if (state_reg.start_cnt != 3'(`SCS_HF_START_CYC)) begin
			state_next.start_cnt = state_reg.start_cnt + 3'h1;
		end
		state_next.hf_ready = state_reg.hf_on &&
			(state_reg.start_cnt == 3'(`SCS_HF_START_CYC));
		state_next.pin_q = external_clock_pin;
		if (ext_edge && ext_halved) begin
			state_next.ext_half = !state_reg.ext_half;
		end
		if (!ext_halved) begin
			state_next.ext_half = 1'b0;
		end
		state_next.pin_claim = mode_runs(state_next.ext_mode);
		// Changes land only at the end of a full period of the old source
		state_next.core_en = state_reg.act_sel ? ext_tick : int_tick;
		if (state_next.core_en) begin
			state_next.act_sel = state_reg.clk_sel;
			state_next.act_div = state_reg.hf_div;
			state_next.div_cnt = 3'h0;
		end else if (state_reg.hf_on) begin
			state_next.div_cnt = state_reg.div_cnt + 3'h1;
		end
		state_next.rdata = 8'h00;
		if (sfr_rd && sfr_addr == `SCS_INT_CTRL_ADDR) begin
			state_next.rdata = {3'h0, state_reg.hf_ready,
				state_reg.clk_sel, state_reg.hf_on,
				state_reg.hf_div};
		end
		if (sfr_rd && sfr_addr == `SCS_EXT_CTRL_ADDR) begin
			state_next.rdata = {1'b0, state_reg.ext_mode, 1'b0,
				state_reg.ext_range};
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg           <= '0;
			state_reg.hf_on     <= 1'b1;
			state_reg.hf_ready  <= 1'b1;
			state_reg.start_cnt <= 3'(`SCS_HF_START_CYC);
			state_reg.hf_div    <= 2'h0;
			state_reg.act_div   <= 2'h0;
			state_reg.clk_sel   <= 1'b0;
			state_reg.act_sel   <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfr_rdata          = state_reg.rdata;
	assign core_clock         = state_reg.core_en;
	assign core_clock_is_ext  = state_reg.act_sel;
	assign hf_osc_on          = state_reg.hf_on;
	assign hf_osc_freq_ready  = state_reg.hf_ready;
	assign ext_osc_mode_sel   = state_reg.ext_mode;
	assign ext_osc_range_ctrl = state_reg.ext_range;
	assign ext_pin_claim      = state_reg.pin_claim;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_rd_int;
		sfr_rd && sfr_addr == `SCS_INT_CTRL_ADDR;
	endsequence
	sequence s_rd_ext;
		sfr_rd && sfr_addr == `SCS_EXT_CTRL_ADDR;
	endsequence
	sequence s_div8_tick;
		core_clock && !state_reg.act_sel && state_reg.act_div == 2'h0;
	endsequence

	property p_int_unused;
		s_rd_int |=> sfr_rdata[7:5] == 3'h0;
	endproperty
	a_int_unused: assert property (p_int_unused)
		else $error("internal control upper bits not zero");

	property p_ready;
		s_rd_int |=> sfr_rdata[4] == $past(hf_osc_freq_ready) &&
			($past(hf_osc_on, 2) || !sfr_rdata[4]);
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready flag read wrong");

	property p_int_src;
		!state_reg.act_sel && int_tick |=> core_clock;
	endproperty
	a_int_src: assert property (p_int_src)
		else $error("internal tick did not reach core clock");

	property p_enable;
		wr_int && !sfr_wdata[2] |=> !hf_osc_on ##1 !hf_osc_freq_ready;
	endproperty
	a_enable: assert property (p_enable)
		else $error("oscillator not disabled");

	property p_div8;
		s_div8_tick |=> (!core_clock)[*7];
	endproperty
	a_div8: assert property (p_div8)
		else $error("divide by eight period too short");

	property p_ext_off;
		wr_ext && sfr_wdata[6:5] == 2'h0 |=> !ext_pin_claim;
	endproperty
	a_ext_off: assert property (p_ext_off)
		else $error("external circuit not off");

	property p_reserved;
		ext_osc_mode_sel[2:1] == 2'h3 |-> !ext_pin_claim && !ext_tick;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved mode produced a tick");

	property p_range;
		wr_ext |=> ext_osc_range_ctrl == $past(sfr_wdata[2:0]);
	endproperty
	a_range: assert property (p_range)
		else $error("range field not stored");

	property p_ext_unused;
		s_rd_ext |=> !sfr_rdata[7] && !sfr_rdata[3];
	endproperty
	a_ext_unused: assert property (p_ext_unused)
		else $error("external control unused bits not zero");

	property p_claim;
		wr_ext && sfr_wdata[6:4] == 3'h4 |=> ext_pin_claim;
	endproperty
	a_claim: assert property (p_claim)
		else $error("RC mode did not claim pin");

	property p_reset;
		$past(sys_rst) |-> state_reg.act_div == 2'h0 && !core_clock_is_ext;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset defaults wrong");

	// Reset itself may move the active divider, so its release is exempt
	property p_switch;
		($changed(core_clock_is_ext) || $changed(state_reg.act_div)) &&
			!$past(sys_rst) |-> core_clock;
	endproperty
	a_switch: assert property (p_switch)
		else $error("source changed mid period");

endmodule
`default_nettype wire

// *** verilog/scs_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCS_EXT_CTRL_ADDR  8'hB1
`define SCS_INT_CTRL_ADDR  8'hB2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCS_EXT_CTRL_RST   8'h00
`define SCS_INT_CTRL_RST   8'h14

// ----------------------------------------
// Internal control fields
// ----------------------------------------
`define SCS_INT_READY_BIT  4
`define SCS_INT_SEL_BIT    3
`define SCS_INT_ON_BIT     2
`define SCS_INT_DIV_HI     1
`define SCS_INT_DIV_LO     0

// ----------------------------------------
// External control fields
// ----------------------------------------
`define SCS_EXT_MODE_HI    6
`define SCS_EXT_MODE_LO    4
`define SCS_EXT_RANGE_HI   2
`define SCS_EXT_RANGE_LO   0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCS_CLK_MHZ        125
`define SCS_HF_START_NS    32
`define SCS_HF_START_CYC   ((`SCS_HF_START_NS*`SCS_CLK_MHZ+999)/1000)

`endif

// *** verilog/scs_pkg.sv ***
// Types for the system clock source select block
package scs_pkg;

	// ----------------------------------------
	// External oscillator modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SCS_EXT_OFF0    = 3'h0,
		SCS_EXT_OFF1    = 3'h1,
		SCS_EXT_CMOS    = 3'h2,
		SCS_EXT_CMOS_D2 = 3'h3,
		SCS_EXT_RC_D2   = 3'h4,
		SCS_EXT_CAP_D2  = 3'h5,
		SCS_EXT_RSV0    = 3'h6,
		SCS_EXT_RSV1    = 3'h7
	} scs_ext_mode_t;

	// ----------------------------------------
	// Complete block state
	// ----------------------------------------
	typedef struct packed {
		logic          clk_sel;
		logic          hf_on;
		logic [1:0]    hf_div;
		logic          hf_ready;
		logic [2:0]    start_cnt;
		scs_ext_mode_t ext_mode;
		logic [2:0]    ext_range;
		logic [2:0]    div_cnt;
		logic          pin_q;
		logic          ext_half;
		logic          act_sel;
		logic [1:0]    act_div;
		logic          core_en;
		logic          pin_claim;
		logic [7:0]    rdata;
	} scs_state_t;

endpackage

// *** dv/scs_ext_clk_src.sv ***
// External CMOS clock source model driving the oscillator pin
`timescale 1ns/1ps
`default_nettype none
module scs_ext_clk_src (
	// Clock and control
	input  wire logic       mclk,
	input  wire logic       run,
	input  wire logic [7:0] half,
	// Oscillator pin
	output wire logic       pin
);
	logic [7:0] cnt = 8'h00;
	logic       lvl = 1'b0;

	// Only this source drives the pin; no other function shares it
	assign pin = lvl;

	// Digital levels only, as a CMOS clock gives
	// Rests low when stopped, so no stray edge reaches the counter
	always @(posedge mclk) begin
		if (!run) begin
			cnt <= 8'h00;
			lvl <= 1'b0;
		end else if (cnt + 8'h01 >= half) begin
			cnt <= 8'h00;
			lvl <= !lvl;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** dv/tb_system_clock_source_select.sv ***
// Self-checking testbench for the system clock source select block
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_select;
	logic       mclk      = 1'b0;
	logic       sys_rst   = 1'b1;
	logic [7:0] sfr_addr  = 8'h00;
	logic       sfr_wr    = 1'b0;
	logic       sfr_rd    = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic       ext_run   = 1'b0;
	logic [7:0] sfr_rdata;
	logic       pin;
	logic       core_clock;
	logic       is_ext;
	logic       hf_on;
	logic       hf_rdy;
	logic [2:0] mode;
	logic [2:0] range;
	logic       claim;
	int         err_count = 0;
	int         cmp_count = 0;

	initial forever #4 mclk = ~mclk;

	scs_ext_clk_src i_src (.mclk(mclk), .run(ext_run), .half(8'h03), .pin(pin));

	scs_clock_select i_dut (.mclk(mclk), .sys_rst(sys_rst),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.external_clock_pin(pin), .core_clock(core_clock),
		.core_clock_is_ext(is_ext), .hf_osc_on(hf_on),
		.hf_osc_freq_ready(hf_rdy), .ext_osc_mode_sel(mode),
		.ext_osc_range_ctrl(range), .ext_pin_claim(claim));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge mclk);
		sfr_wr    <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge mclk);
		sfr_rd   <= 1'b0;
		#1;
		chk(sfr_rdata, exp, "register read");
	endtask

	// Bounded at 64 cycles, so a stalled clock shows up as a bad gap
	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (core_clock !== 1'b1 && n < 64);
	endtask

	// First two gaps are dropped: they may straddle a pending source change
	task automatic period(input int exp);
		int n;
		wait_pulse(n);
		wait_pulse(n);
		wait_pulse(n);
		chk(8'(n), 8'(exp), "core clock period");
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#20000;
		err_count++;
		final_report();
	end

	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		rchk(8'hB2, 8'h14);
		rchk(8'hB1, 8'h00);
		rchk(8'hB0, 8'h00);
		period(8);
		for (int d = 0; d < 4; d++) begin
			sfr_write(8'hB2, 8'hE4 | 8'(d));
			rchk(8'hB2, 8'h14 | 8'(d));
			period(8 >> d);
		end
		for (int m = 0; m < 8; m++) begin
			sfr_write(8'hB1, {1'b1, 3'(m), 1'b1, 3'(m)});
			rchk(8'hB1, {1'b0, 3'(m), 1'b0, 3'(m)});
			chk({5'h00, mode}, 8'(m), "mode field");
			chk({5'h00, range}, 8'(m), "range field");
			chk({7'h00, claim}, {7'h00, m >= 2 && m <= 5}, "claim");
		end
		// Source is running before it is selected
		@(posedge mclk);
		ext_run <= 1'b1;
		sfr_write(8'hB1, 8'h20);
		sfr_write(8'hB2, 8'h0F);
		period(6);
		chk({7'h00, is_ext}, 8'h01, "source ext");
		for (int m = 3; m < 6; m++) begin
			sfr_write(8'hB1, {1'b0, 3'(m), 4'h0});
			period(12);
		end
		sfr_write(8'hB2, 8'h08);
		@(posedge mclk);
		rchk(8'hB2, 8'h08);
		chk({7'h00, hf_on}, 8'h00, "osc off");
		chk({7'h00, hf_rdy}, 8'h00, "ready low");
		sfr_write(8'hB2, 8'h0C);
		repeat (10) @(posedge mclk);
		rchk(8'hB2, 8'h1C);
		chk({7'h00, hf_rdy}, 8'h01, "ready high");
		sfr_write(8'hB2, 8'h07);
		period(1);
		chk({7'h00, is_ext}, 8'h00, "source int");
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		ext_run <= 1'b0;
		rchk(8'hB2, 8'h14);
		rchk(8'hB1, 8'h00);
		period(8);
		final_report();
	end
endmodule
`default_nettype wire
